// ===== src/pllrc_pkg.sv
// constants and types for the pll clock ratio control block
package pllrc_pkg;
  localparam int unsigned RATIO_W        = 4;
  localparam int unsigned REG_W          = 16;
  localparam logic [3:0]  RATIO_RESET    = 4'h0;
  localparam logic [3:0]  RATIO_BYPASS   = 4'h0;
  localparam logic [3:0]  RATIO_MAX      = 4'hA;
  localparam int unsigned LOCK_CYCLES    = 131072;
  localparam int unsigned LOCK_W         = 18;
  localparam int unsigned LOSS_CYCLES    = 8;
  localparam int unsigned LOSS_W         = 4;

  typedef enum logic [1:0]
  {
    PLLRC_DISABLED = 2'h0,
    PLLRC_BYPASS   = 2'h1,
    PLLRC_LOCKING  = 2'h2,
    PLLRC_ENABLED  = 2'h3
  } pllrc_mode_e;

  typedef struct packed
  {
    logic        wr_en;
    logic        unlock;
    logic [15:0] wr_data;
  } pllrc_wr_s;

  typedef struct packed
  {
    pllrc_mode_e mode;
    logic [3:0]  ratio;
    logic        limp;
    logic        reserved_code;
    logic        stable;
  } pllrc_stat_s;
endpackage

// ===== src/pllrc_top.sv
// pll clock ratio control: ratio register, mode tracking, lock timing, loss detection
`timescale 1ns/1ps
`default_nettype none
module pllrc_top
  import pllrc_pkg::*;
#(
  parameter int unsigned LOCK_COUNT = pllrc_pkg::LOCK_CYCLES
)
(
  input  wire logic              clk_sys_in,
  input  wire logic              rst_in,
  input  wire logic              pll_disable_strap_n_in,
  input  wire logic              input_clock_tick_in,
  input  wire pllrc_pkg::pllrc_wr_s wr_in,
  output logic [15:0]            pll_ratio_control_out,
  output pllrc_pkg::pllrc_stat_s stat_out,
  output logic                   core_clock_div2_out,
  output logic [3:0]             pll_multiplier_out,
  output logic                   watchdog_hold_out
);
  import pllrc_pkg::*;

  // the pll itself is analog and lives outside; this block only decides
  // what it is told to do and what software sees of it.
  // modes:
  //   disabled - strap low at reset, core clock taken undivided
  //   bypass   - default after reset, input clock halved
  //   locking  - new ratio written, waiting out the settle time
  //   enabled  - ratio applied, pll output halved
  // the input clock is seen as a tick per cycle in the system domain, so
  // the settle count is in input clock cycles, not system cycles.
  // loss of input is judged by a short tick-free window; an input clock
  // slower than that window would be mistaken for a lost one.
  // the limp clock itself comes from the analog pll, it is only flagged here.
  // the ratio register holds reserved codes as written; flagging them is
  // cheaper than silently altering what software reads back.

  // every register of the block lives in this one record
  typedef struct packed
  {
    // control state
    logic                strap_seen;
    logic                pll_off;
    logic [3:0]          ratio;
    pllrc_mode_e         mode;
    logic [LOCK_W-1:0]   lock_cnt;
    logic [LOSS_W-1:0]   loss_cnt;
    logic                limp;
    // registered port copies
    logic [REG_W-1:0]    reg_q;
    pllrc_stat_s         stat_q;
    logic                div2_q;
    logic [RATIO_W-1:0]  mult_q;
    logic                hold_q;
  } pllrc_state_s;

  pllrc_state_s st;
  pllrc_state_s next_st;

  // codes above ten are stored as written but flagged for software
  function automatic logic is_reserved(input logic [3:0] code);
    is_reserved = code > RATIO_MAX;
  endfunction

  // pll in use: locking toward or locked at a ratio
  function automatic logic is_running(input pllrc_mode_e m);
    is_running = (m == PLLRC_LOCKING) || (m == PLLRC_ENABLED);
  endfunction

  // core clock settled: bypass needs no lock, enabled has locked
  function automatic logic is_settled(input pllrc_mode_e m);
    is_settled = (m == PLLRC_ENABLED) || (m == PLLRC_BYPASS);
  endfunction

  // zero parks the pll in bypass; every other code restarts a lock
  function automatic pllrc_mode_e mode_after_write(input logic [3:0] code);
    mode_after_write = (code == RATIO_BYPASS) ? PLLRC_BYPASS : PLLRC_LOCKING;
  endfunction

  // a write is only honoured once the strap is known and the pll exists
  function automatic logic write_taken(input pllrc_wr_s wr, input logic seen, input logic off);
    write_taken = wr.wr_en && wr.unlock && seen && !off;
  endfunction

  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_COUNT - 1);
  localparam logic [LOSS_W-1:0] LOSS_LAST = LOSS_W'(LOSS_CYCLES);
  localparam int unsigned       PAD_W     = REG_W - RATIO_W;

  always_comb
  begin
    next_st = st;

    // strap is caught on the first clock after hard reset release
    if (!st.strap_seen)
    begin
      next_st.strap_seen = 1'b1;
      next_st.pll_off    = !pll_disable_strap_n_in;
    end

    // loss detector: no input tick for a while means the oscillator is gone;
    // the count saturates so a long outage cannot wrap back to healthy
    if (input_clock_tick_in)
    begin
      next_st.loss_cnt = '0;
    end
    else if (st.loss_cnt != LOSS_LAST)
    begin
      next_st.loss_cnt = st.loss_cnt + LOSS_W'(1);
    end
    // limp needs a running pll: in bypass there is nothing to fall back on
    next_st.limp = is_running(st.mode) && (st.loss_cnt == LOSS_LAST);

    // ratio register and mode sequencing
    if (write_taken(wr_in, st.strap_seen, st.pll_off))
    begin
      next_st.ratio    = wr_in.wr_data[RATIO_W-1:0];
      next_st.lock_cnt = '0;
      next_st.mode     = mode_after_write(wr_in.wr_data[RATIO_W-1:0]);
    end
    else
    begin
      case (st.mode)
        PLLRC_DISABLED:
        begin
          if (st.strap_seen && !st.pll_off)
          begin
            next_st.mode = PLLRC_BYPASS;
          end
        end
        PLLRC_LOCKING:
        begin
          // only real input clock cycles count toward lock, so a dead
          // oscillator never reports a settled pll
          if (input_clock_tick_in)
          begin
            if (st.lock_cnt == LOCK_LAST)
            begin
              next_st.mode = PLLRC_ENABLED;
            end
            else
            begin
              next_st.lock_cnt = st.lock_cnt + LOCK_W'(1);
            end
          end
        end
        PLLRC_BYPASS:
        begin
          // nothing to settle while bypassed
          next_st.lock_cnt = '0;
        end
        PLLRC_ENABLED:
        begin
          // a locked pll stays put until the next write or reset
          next_st.lock_cnt = st.lock_cnt;
        end
        default:
        begin
          next_st.mode = PLLRC_DISABLED;
        end
      endcase
    end

    // a strapped-off pll overrides everything, writes included
    if (st.strap_seen && st.pll_off)
    begin
      next_st.mode = PLLRC_DISABLED;
    end

    // port copies come from the next state so that every output is a flop
    next_st.reg_q                = {{PAD_W{1'b0}}, next_st.ratio}; // reserved bits read zero
    next_st.stat_q.mode          = next_st.mode;
    next_st.stat_q.ratio         = next_st.ratio;
    next_st.stat_q.limp          = next_st.limp;
    next_st.stat_q.reserved_code = is_reserved(next_st.ratio);
    next_st.stat_q.stable        = is_settled(next_st.mode);
    next_st.div2_q               = next_st.mode != PLLRC_DISABLED;
    next_st.mult_q               = is_running(next_st.mode) ? next_st.ratio : 4'h0;
    next_st.hold_q               = next_st.limp;
  end

  // only the hard reset pin reaches this block; debug resets never do,
  // so a programmed ratio survives a debugger halt
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      st.strap_seen            <= 1'b0;
      st.pll_off               <= 1'b0;
      st.ratio                 <= RATIO_RESET;
      st.mode                  <= PLLRC_DISABLED;
      st.lock_cnt              <= '0;
      st.loss_cnt              <= '0;
      st.limp                  <= 1'b0;
      st.reg_q                 <= 16'h0000;
      st.stat_q.mode           <= PLLRC_DISABLED;
      st.stat_q.ratio          <= RATIO_RESET;
      st.stat_q.limp           <= 1'b0;
      st.stat_q.reserved_code  <= 1'b0;
      st.stat_q.stable         <= 1'b0;
      st.div2_q                <= 1'b0;
      st.mult_q                <= 4'h0;
      st.hold_q                <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs are plain wires from the state flops
  assign pll_ratio_control_out = st.reg_q;
  assign stat_out              = st.stat_q;
  assign core_clock_div2_out   = st.div2_q;
  assign pll_multiplier_out    = st.mult_q;
  assign watchdog_hold_out     = st.hold_q;
endmodule
`default_nettype wire

// ===== verif/pllrc_top_sva.sv
// assertions on the ports of the pll clock ratio control block
`timescale 1ns/1ps
`default_nettype none
module pllrc_sva
  import pllrc_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic        pll_disable_strap_n_in,
  input wire logic        input_clock_tick_in,
  input wire pllrc_pkg::pllrc_wr_s   wr_in,
  input wire logic [15:0]            pll_ratio_control_out,
  input wire pllrc_pkg::pllrc_stat_s stat_out,
  input wire logic        core_clock_div2_out,
  input wire logic [3:0]  pll_multiplier_out,
  input wire logic        watchdog_hold_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  wire run = stat_out.mode[1];
  sequence quiet; (run && !input_clock_tick_in) [*8]; endsequence
  a_write_lands: assert property (wr_in.wr_en && wr_in.unlock && |stat_out.mode
    |=> pll_ratio_control_out == $past(wr_in.wr_data[3:0])) else $error("lost");
  a_locked_ignored: assert property (wr_in.wr_en && !wr_in.unlock
    |=> $stable(pll_ratio_control_out)) else $error("taken");
  a_mult_ratio: assert property (pll_multiplier_out == (run ? stat_out.ratio : 4'h0))
    else $error("mult");
  a_div_mode: assert property (core_clock_div2_out == |stat_out.mode)
    else $error("div");
  a_code_flag: assert property (stat_out.reserved_code == (stat_out.ratio > 4'hA))
    else $error("flag");
  a_new_unstable: assert property ($changed(stat_out.ratio) && |stat_out.ratio
    |-> !stat_out.stable) else $error("early");
  a_loss_limp: assert property (quiet |-> ##[1:3] watchdog_hold_out && stat_out.limp)
    else $error("limp");
  a_tick_clears: assert property (watchdog_hold_out && input_clock_tick_in
    |-> ##[1:3] !watchdog_hold_out) else $error("hold");
endmodule
bind pllrc_top pllrc_sva chk_i
(
  .clk_sys_in             (clk_sys_in),
  .rst_in                 (rst_in),
  .pll_disable_strap_n_in (pll_disable_strap_n_in),
  .input_clock_tick_in    (input_clock_tick_in),
  .wr_in                  (wr_in),
  .pll_ratio_control_out  (pll_ratio_control_out),
  .stat_out               (stat_out),
  .core_clock_div2_out    (core_clock_div2_out),
  .pll_multiplier_out     (pll_multiplier_out),
  .watchdog_hold_out      (watchdog_hold_out)
);
`default_nettype wire

// ===== verif/test_pllrc_top.sv
// self-checking bench for the pll clock ratio control block
`timescale 1ns/1ps
`default_nettype none
module test_pllrc_top;
  import pllrc_pkg::*;
  logic        clk_sys_in = 0, rst_in = 1, strap_n = 1, tick = 1, div2, hold;
  logic [15:0] rd;
  logic [3:0]  mult;
  pllrc_wr_s   wr = '0;
  pllrc_stat_s st;
  int          bad_count = 0, comparisons = 0, ratio = 0;
  pllrc_top #(.LOCK_COUNT(16)) uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .pll_disable_strap_n_in(strap_n), .input_clock_tick_in(tick), .wr_in(wr),
    .pll_ratio_control_out(rd), .stat_out(st), .core_clock_div2_out(div2),
    .pll_multiplier_out(mult), .watchdog_hold_out(hold));
  always #5 clk_sys_in = ~clk_sys_in;
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e)
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    bad_count += 32'(s !== e);
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  // strobe stays up so writes can run back to back
  task automatic put(input logic u, input logic [15:0] d);
    wr = '{1'b1, u, d};
    step(1);
    if (u && strap_n)
      ratio = 32'(d[3:0]);
    chk("reg", rd, 16'(ratio));
    chk("ratio", 16'(st.ratio), 16'(ratio));
    chk("mult", 16'(mult), 16'(ratio));
    chk("flags", 16'({st.reserved_code, st.stable, div2}), 16'({ratio > 10, strap_n && !ratio, strap_n}));
  endtask
  task automatic complete_run;
    $display("%0d checks %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    step(7);
    rst_in = 0;
    void'($urandom(32'hDBBB));
    step(3);
    repeat (10)
      put(1'($urandom), 16'($urandom));
    put(1, 16'h0005); // watchdog left running while the ratio changes
    wr.wr_en = 0;
    $display("writes done");
    step(8);
    chk("locking", 16'(st.stable), 16'h0000);
    step(16);
    chk("locked", 16'(st.mode), 16'(PLLRC_ENABLED));
    // input lost: core keeps a halved clock with the old multiplier
    tick = 0;
    step(12);
    chk("limp", 16'({hold, st.limp, div2, mult}), 16'h0075);
    tick = 1;
    step(4);
    chk("hold", 16'(hold), 16'h0000);
    put(1, 16'h0000);
    put(0, 16'h0003);
    wr.wr_en = 0;
    $display("loss done");
    rst_in = 1;
    strap_n = 0;
    ratio = 0;
    step(2);
    chk("reset", rd, 16'h0000);
    rst_in = 0;
    step(3);
    put(1, 16'h0007);
    wr.wr_en = 0;
    $display("strap done");
    complete_run;
  end
endmodule
`default_nettype wire
